// File: rocx_core.sv
/*
 * Range offset trim, cross-talk rate store and range-ignore check.
 * Assumes an 8-bit register port from the serial interface logic, with
 * a one-cycle write strobe and a read answer one cycle after the address,
 * and a ranging core that presents one raw result with a one-cycle valid.
 */
// What this block and the host do
// R1: offset trim is signed 8-bit two's complement
// R2: host zeroes offset trim before calibration
// R3: host uses 50 mm calibration target
// R4: host averages at least ten ranges
// R5: offset equals 50 minus averaged range
// R6: host writes signed offset to trim
// R7: host calibrates offset before cross talk
// R8: host uses dark target at 100 mm
// R9: host zeroes cross-talk rate while gathering
// R10: host averages range and return rate
// R11: cross talk is rate times range deficit
// R12: host writes cross talk to rate register
// R13: cross-talk rate is unsigned 9.7 format
// R14: ignore check only when enable bit 1
// R15: host programs threshold when enabling ignore
// R16: host sets threshold to 1.2x cross talk
// R17: rate below threshold flags ignore error
// R18: ignore error is code 8, range 255
// R19: status updated after every measurement
// R20: return rate scaled 1/128 Mcps like cross talk
// R21: host rounds and saturates offset
// R22: trim added to raw range before classification
`timescale 1ns/1ps
`default_nettype none

module rocx_core (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  // Ranging core
  input  wire logic              meas_valid,
  input  wire rocx_pkg::rocx_meas_t meas,
  // Results and settings to the ranging core
  output logic                   result_valid,
  output logic      [7:0]        range_val,
  output logic      [3:0]        range_error,
  output logic      [15:0]       xtalk_rate
);

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  logic [15:0] xtalk_q;
  logic [7:0]  trim_q;
  logic [15:0] thr_q;
  logic [7:0]  chk_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      xtalk_q <= rocx_pkg::XTALK_RATE_RST;
      trim_q  <= rocx_pkg::OFFSET_TRIM_RST;
      thr_q   <= rocx_pkg::IGNORE_THR_RST;
      chk_q   <= rocx_pkg::CHECK_ENABLES_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        rocx_pkg::XTALK_RATE_HI_ADDR: xtalk_q[15:8] <= reg_wdata; // [R13]
        rocx_pkg::XTALK_RATE_LO_ADDR: xtalk_q[7:0]  <= reg_wdata; // [R13]
        rocx_pkg::OFFSET_TRIM_ADDR:   trim_q        <= reg_wdata;
        rocx_pkg::IGNORE_THR_HI_ADDR: thr_q[15:8]   <= reg_wdata;
        rocx_pkg::IGNORE_THR_LO_ADDR: thr_q[7:0]    <= reg_wdata;
        rocx_pkg::CHECK_ENABLES_ADDR: chk_q         <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Measurement pipeline
  // ****************************************************************
  rocx_pkg::rocx_state_t state_q;
  rocx_pkg::rocx_meas_t  meas_q;
  logic [7:0]  status_q;
  logic [15:0] rate_q;

  // Trimmed range, sign-extended to catch both ends
  logic signed [9:0] trimmed;
  logic              ignore_fail;
  assign trimmed = $signed({2'b00, meas_q.raw_range})
                 + $signed({{2{trim_q[7]}}, trim_q}); // [R1] [R22]
  assign ignore_fail = chk_q[rocx_pkg::IGNORE_EN_BIT]
                     && (meas_q.return_rate < thr_q); // [R14] [R17] [R20]

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= rocx_pkg::PH_IDLE;
      meas_q  <= '0;
    end else begin
      case (state_q)
        rocx_pkg::PH_IDLE: begin
          if (meas_valid) begin
            meas_q  <= meas;
            state_q <= rocx_pkg::PH_CHECK;
          end
        end
        rocx_pkg::PH_CHECK: state_q <= rocx_pkg::PH_POST;
        rocx_pkg::PH_POST:  state_q <= rocx_pkg::PH_IDLE;
        default:            state_q <= rocx_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_q     <= rocx_pkg::RANGE_STATUS_RST;
      range_val    <= rocx_pkg::RANGE_MIN_VAL;
      range_error  <= rocx_pkg::ERR_NONE;
      rate_q       <= 16'h0000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (state_q == rocx_pkg::PH_CHECK) begin
        result_valid <= 1'b1;
        rate_q       <= meas_q.return_rate;
        if (ignore_fail) begin
          range_val   <= rocx_pkg::RANGE_FAIL_VAL; // [R18]
          range_error <= rocx_pkg::ERR_IGNORE;
          status_q    <= {rocx_pkg::ERR_IGNORE, 4'h1}; // [R19]
        end else if (trimmed < 0) begin
          range_val   <= rocx_pkg::RANGE_MIN_VAL;
          range_error <= rocx_pkg::ERR_RAW_UNDERFLOW;
          status_q    <= {rocx_pkg::ERR_RAW_UNDERFLOW, 4'h1}; // [R19]
        end else if (trimmed > $signed(rocx_pkg::RANGE_MAX_VALID)) begin
          range_val   <= rocx_pkg::RANGE_FAIL_VAL;
          range_error <= rocx_pkg::ERR_RAW_OVERFLOW;
          status_q    <= {rocx_pkg::ERR_RAW_OVERFLOW, 4'h1}; // [R19]
        end else begin
          range_val   <= trimmed[7:0]; // [R22]
          range_error <= rocx_pkg::ERR_NONE;
          status_q    <= {rocx_pkg::ERR_NONE, 4'h1}; // [R19]
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      xtalk_rate <= rocx_pkg::XTALK_RATE_RST;
    end else begin
      xtalk_rate <= xtalk_q; // [R13]
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          rocx_pkg::XTALK_RATE_HI_ADDR:  reg_rdata <= xtalk_q[15:8];
          rocx_pkg::XTALK_RATE_LO_ADDR:  reg_rdata <= xtalk_q[7:0];
          rocx_pkg::OFFSET_TRIM_ADDR:    reg_rdata <= trim_q;
          rocx_pkg::IGNORE_THR_HI_ADDR:  reg_rdata <= thr_q[15:8];
          rocx_pkg::IGNORE_THR_LO_ADDR:  reg_rdata <= thr_q[7:0];
          rocx_pkg::CHECK_ENABLES_ADDR:  reg_rdata <= chk_q;
          rocx_pkg::RANGE_STATUS_ADDR:   reg_rdata <= status_q;
          rocx_pkg::RANGE_VAL_ADDR:      reg_rdata <= range_val;
          rocx_pkg::RETURN_RATE_HI_ADDR: reg_rdata <= rate_q[15:8]; // [R20]
          rocx_pkg::RETURN_RATE_LO_ADDR: reg_rdata <= rate_q[7:0];
          default:                       reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence meas_in_s;
    meas_valid && state_q == rocx_pkg::PH_IDLE;
  endsequence

  sequence result_out_s;
    ##2 result_valid;
  endsequence

  result_follows_a: assert property (@(posedge clk) disable iff (!resetn) // [R19]
    meas_in_s |-> result_out_s)
    else $error("Result not two cycles after measurement");

  ignore_code_a: assert property (@(posedge clk) disable iff (!resetn) // [R18]
    result_valid && range_error == rocx_pkg::ERR_IGNORE |->
      range_val == 8'hFF && status_q[7:4] == 4'h8)
    else $error("Ignore error not coded as 8 with 255");

  ignore_gate_a: assert property (@(posedge clk) disable iff (!resetn) // [R14]
    state_q == rocx_pkg::PH_CHECK && !chk_q[1] |=>
      range_error != rocx_pkg::ERR_IGNORE)
    else $error("Ignore flagged while disabled");

  ignore_low_a: assert property (@(posedge clk) disable iff (!resetn) // [R17]
    state_q == rocx_pkg::PH_CHECK && chk_q[1] && meas_q.return_rate < thr_q |=>
      range_error == rocx_pkg::ERR_IGNORE)
    else $error("Low rate not flagged");

  trim_add_a: assert property (@(posedge clk) disable iff (!resetn) // [R22]
    state_q == rocx_pkg::PH_CHECK && !ignore_fail && trimmed >= 0
      && trimmed <= 10'sh0FE |=>
      range_val == $past(trimmed[7:0]) && range_error == 4'h0)
    else $error("Trimmed range wrong");

  trim_neg_a: assert property (@(posedge clk) disable iff (!resetn) // [R1]
    state_q == rocx_pkg::PH_CHECK && !ignore_fail && trim_q[7]
      && meas_q.raw_range < {1'b0, ~trim_q[6:0]} + 8'h01 |=>
      range_error == rocx_pkg::ERR_RAW_UNDERFLOW && range_val == 8'h00)
    else $error("Negative trim underflow missed");

  status_ready_a: assert property (@(posedge clk) disable iff (!resetn) // [R19]
    result_valid |-> status_q[3:0] == 4'h1 && status_q[7:4] == range_error)
    else $error("Status not matching result");

  xtalk_hold_a: assert property (@(posedge clk) disable iff (!resetn) // [R13]
    reg_wr && reg_addr == 8'h1E |=> ##1 xtalk_rate[15:8] == $past(reg_wdata, 2))
    else $error("Cross-talk rate not forwarded");

endmodule // rocx_core

`default_nettype wire

// File: rocx_core_tb_top.sv
/* Testbench for rocx_core: reset values, calibration, ignore cases.
   Assumes rocx_pkg and rocx_host_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rocx_core_tb_top;
  logic clk;
  logic resetn;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, range_val;
  logic reg_wr, reg_rd, reg_rvalid, meas_valid, result_valid;
  logic [3:0] range_error;
  logic [15:0] xtalk_rate;
  rocx_pkg::rocx_meas_t meas;
  int fails = 0;
  int n_compared = 0;
  logic [7:0] rst_addr [7] = '{8'h1E, 8'h1F, 8'h24, 8'h26, 8'h27, 8'h2D, 8'h50};
  // Trim, enables, raw, rate, range, code
  logic [51:0] cases [8] = '{
    {8'hF6, 8'h02, 8'h5A, 16'h003C, 8'hFF, 4'h8},
    {8'hF6, 8'h02, 8'h5A, 16'h003D, 8'h50, 4'h0},
    {8'hF6, 8'h01, 8'h5A, 16'h0010, 8'h50, 4'h0},
    {8'h7F, 8'h00, 8'h64, 16'h0010, 8'hE3, 4'h0},
    {8'h80, 8'h00, 8'h64, 16'h0010, 8'h00, 4'hC},
    {8'h0A, 8'h00, 8'hFA, 16'h0010, 8'hFF, 4'hD},
    {8'h00, 8'h00, 8'hFE, 16'h0010, 8'hFE, 4'h0},
    {8'h80, 8'h02, 8'h0A, 16'h0010, 8'hFF, 4'h8}};
  initial clk = 1'b0;
  always #4 clk = ~clk;
  rocx_core rocx_core_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .meas_valid(meas_valid), .meas(meas),
    .result_valid(result_valid), .range_val(range_val), .range_error(range_error),
    .xtalk_rate(xtalk_rate));
  rocx_host_model rocx_host_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .meas_valid(meas_valid), .meas(meas),
    .result_valid(result_valid));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rocx_host_model_inst.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
  endtask
  task automatic mchk(input logic [51:0] c);
    rocx_host_model_inst.wr(rocx_pkg::OFFSET_TRIM_ADDR, c[51:44]);
    rocx_host_model_inst.wr(rocx_pkg::CHECK_ENABLES_ADDR, c[43:36]);
    rocx_host_model_inst.measure(c[35:28], c[27:12]);
    chk("result_valid", 16'h0001, {15'h0000, result_valid});
    chk("range_val", {8'h00, c[11:4]}, {8'h00, range_val});
    chk("range_error", {12'h000, c[3:0]}, {12'h000, range_error});
    rchk(rocx_pkg::RANGE_STATUS_ADDR, {c[3:0], 4'h1});
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    fails++;
    give_verdict();
  end
  initial begin
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    foreach (rst_addr[i]) rchk(rst_addr[i], 8'h00);
    rchk(rocx_pkg::RANGE_STATUS_ADDR, 8'h01);
    rocx_host_model_inst.wr(8'h50, 8'hAA);
    rchk(8'h50, 8'h00);
    rocx_host_model_inst.wr(rocx_pkg::RANGE_STATUS_ADDR, 8'hF0);
    rchk(rocx_pkg::RANGE_STATUS_ADDR, 8'h01);
    $display("test reset and map done");
    rocx_host_model_inst.offset_cal(8'h3C);
    rchk(rocx_pkg::OFFSET_TRIM_ADDR, 8'hF6);
    rocx_host_model_inst.measure(8'h3C, 16'h0100);
    chk("range_val", 16'h0032, {8'h00, range_val});
    $display("test offset calibration done");
    rocx_host_model_inst.xtalk_cal(8'h5A, 16'h0100);
    rchk(rocx_pkg::XTALK_RATE_LO_ADDR, 8'h33);
    rchk(rocx_pkg::IGNORE_THR_LO_ADDR, 8'h3D);
    chk("xtalk_rate", 16'h0033, xtalk_rate);
    $display("test cross-talk calibration done");
    foreach (cases[i]) mchk(cases[i]);
    rchk(rocx_pkg::RANGE_STATUS_ADDR, 8'h81);
    $display("test ignore and classification done");
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    chk("range_val", 16'h0000, {8'h00, range_val});
    chk("range_error", 16'h0000, {12'h000, range_error});
    chk("xtalk_rate", 16'h0000, xtalk_rate);
    chk("result_valid", 16'h0000, {15'h0000, result_valid});
    rchk(rocx_pkg::OFFSET_TRIM_ADDR, 8'h00);
    rchk(rocx_pkg::IGNORE_THR_LO_ADDR, 8'h00);
    rchk(rocx_pkg::CHECK_ENABLES_ADDR, 8'h00);
    rchk(rocx_pkg::RANGE_STATUS_ADDR, 8'h01);
    $display("test reset in mid-run done");
    give_verdict();
  end
endmodule // rocx_core_tb_top
`default_nettype wire

// File: rocx_host_model.sv
/* Host and ranging-core stand-in for rocx_core: register port tasks,
   measurement task, offset and cross-talk calibration.
   Assumes the core samples its strobes on the rising edge of clk. */
`timescale 1ns/1ps
`default_nettype none
module rocx_host_model (
  // Clock
  input  wire logic            clk,
  // Register port
  output logic [7:0]           reg_addr,
  output logic                 reg_wr,
  output logic [7:0]           reg_wdata,
  output logic                 reg_rd,
  input  wire logic [7:0]      reg_rdata,
  input  wire logic            reg_rvalid,
  // Ranging core side
  output logic                 meas_valid,
  output rocx_pkg::rocx_meas_t meas,
  input  wire logic            result_valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    meas_valid = 1'b0;
    meas = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    d = reg_rvalid === 1'b1 ? reg_rdata : 8'hXX;
  endtask
  task automatic measure(input logic [7:0] raw, input logic [15:0] rate);
    int i;
    @(posedge clk);
    meas_valid <= 1'b1;
    meas <= rocx_pkg::rocx_meas_t'({raw, rate});
    @(posedge clk);
    meas_valid <= 1'b0;
    meas <= rocx_pkg::rocx_meas_t'(~{raw, rate});
    #1;
    for (i = 0; i < 4 && result_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  // ****************************************************************
  // Calibration procedures
  // ****************************************************************
  task automatic offset_cal(input logic [7:0] raw);
    int sum;
    int off;
    logic [7:0] v;
    sum = 0;
    wr(rocx_pkg::OFFSET_TRIM_ADDR, 8'h00);
    repeat (10) begin
      measure(raw, 16'h0100);
      rd(rocx_pkg::RANGE_VAL_ADDR, v);
      sum += v;
    end
    off = 50 - (sum + 5) / 10;
    off = off > 127 ? 127 : (off < -128 ? -128 : off);
    wr(rocx_pkg::OFFSET_TRIM_ADDR, off[7:0]);
  endtask
  task automatic xtalk_cal(input logic [7:0] raw, input logic [15:0] rate);
    int rs;
    int ss;
    int xt;
    logic [7:0] v;
    logic [7:0] h;
    rs = 0;
    ss = 0;
    wr(rocx_pkg::XTALK_RATE_HI_ADDR, 8'h00);
    wr(rocx_pkg::XTALK_RATE_LO_ADDR, 8'h00);
    repeat (10) begin
      measure(raw, rate);
      rd(rocx_pkg::RANGE_VAL_ADDR, v);
      rs += v;
      rd(rocx_pkg::RETURN_RATE_HI_ADDR, h);
      rd(rocx_pkg::RETURN_RATE_LO_ADDR, v);
      ss += {h, v};
    end
    xt = (ss * (1000 - rs) + 5000) / 10000;
    wr(rocx_pkg::XTALK_RATE_HI_ADDR, xt[15:8]);
    wr(rocx_pkg::XTALK_RATE_LO_ADDR, xt[7:0]);
    xt = (xt * 12 + 5) / 10;
    wr(rocx_pkg::IGNORE_THR_HI_ADDR, xt[15:8]);
    wr(rocx_pkg::IGNORE_THR_LO_ADDR, xt[7:0]);
    wr(rocx_pkg::CHECK_ENABLES_ADDR, 8'h02);
  endtask
endmodule // rocx_host_model
`default_nettype wire

// File: rocx_pkg.sv
/*
 * Package for the range calibration and compensation block: register
 * offsets, field positions, reset values, error codes and carrier types.
 * Assumes a register port that addresses 8-bit registers by index.
 */
`default_nettype none

package rocx_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] XTALK_RATE_HI_ADDR   = 8'h1E;
  localparam logic [7:0] XTALK_RATE_LO_ADDR   = 8'h1F;
  localparam logic [7:0] OFFSET_TRIM_ADDR     = 8'h24;
  localparam logic [7:0] IGNORE_THR_HI_ADDR   = 8'h26;
  localparam logic [7:0] IGNORE_THR_LO_ADDR   = 8'h27;
  localparam logic [7:0] CHECK_ENABLES_ADDR   = 8'h2D;
  localparam logic [7:0] RANGE_STATUS_ADDR    = 8'h4D;
  localparam logic [7:0] RANGE_VAL_ADDR       = 8'h62;
  localparam logic [7:0] RETURN_RATE_HI_ADDR  = 8'h66;
  localparam logic [7:0] RETURN_RATE_LO_ADDR  = 8'h67;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int          IGNORE_EN_BIT       = 1;
  localparam int          ERR_LSB             = 4;
  localparam int          READY_BIT           = 0;
  localparam logic [15:0] XTALK_RATE_RST      = 16'h0000;
  localparam logic [7:0]  OFFSET_TRIM_RST     = 8'h00;
  localparam logic [15:0] IGNORE_THR_RST      = 16'h0000;
  localparam logic [7:0]  CHECK_ENABLES_RST   = 8'h00;
  localparam logic [7:0]  RANGE_STATUS_RST    = 8'h01;

  // ****************************************************************
  // Range results
  // ****************************************************************
  localparam logic [3:0]  ERR_NONE            = 4'h0;
  localparam logic [3:0]  ERR_IGNORE          = 4'h8;
  localparam logic [3:0]  ERR_RAW_UNDERFLOW   = 4'hC;
  localparam logic [3:0]  ERR_RAW_OVERFLOW    = 4'hD;
  localparam logic [7:0]  RANGE_FAIL_VAL      = 8'hFF;
  localparam logic [7:0]  RANGE_MIN_VAL       = 8'h00;
  localparam logic [9:0]  RANGE_MAX_VALID     = 10'h0FE;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_CHECK = 2'b01,
    PH_POST  = 2'b11
  } rocx_state_t;

  // Raw measurement from the ranging core
  typedef struct packed {
    logic [7:0]  raw_range;
    logic [15:0] return_rate;
  } rocx_meas_t;

endpackage : rocx_pkg

`default_nettype wire
